/* File: verilog/sfm_pkg.sv */
// Package of constants and types for the servo fault manager
package sfm_pkg;

    // Number of fault detector inputs; index 0 is the highest priority
    localparam int unsigned NUM_FAULTS = 8;
    // Fault index of bus over-voltage
    localparam int unsigned OV_IDX = 0;
    // Width of the ADC bus voltage sample
    localparam int unsigned VBUS_W = 12;
    // Width of a fault code / blink count
    localparam int unsigned CODE_W = 5;

    // Clock rate in kHz
    localparam int unsigned CLK_KHZ = 50000;
    // Self-reset recovery delay, ms (allowed window 50 to 100 ms)
    localparam int unsigned RECOVER_MS = 75;
    // Cycles of recovery delay, derived from rate
    localparam int unsigned RECOVER_CYC = RECOVER_MS * CLK_KHZ;
    // LED blink on/off phase, ms, and gap between code repeats
    localparam int unsigned BLINK_MS = 250;
    localparam int unsigned BLINK_CYC = BLINK_MS * CLK_KHZ;
    localparam int unsigned GAP_BLINKS = 4;

    // Latching class per fault (bit set = latching); over-voltage never latches
    localparam logic [NUM_FAULTS-1:0] LATCH_MASK = 8'hfe;
    // Blink code reported for each fault index, priority order by index
    localparam logic [NUM_FAULTS*CODE_W-1:0] CODE_TABLE =
        {5'h08, 5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01};
    // Reset values
    localparam logic [CODE_W-1:0] CODE_NONE = 5'h00;

    // LED sequencer states
    typedef enum logic [1:0] {
        SFM_LED_IDLE = 2'b00,
        SFM_LED_ON   = 2'b01,
        SFM_LED_OFF  = 2'b10,
        SFM_LED_GAP  = 2'b11
    } sfm_led_state_t;

endpackage : sfm_pkg

/* File: verilog/sfm_led_if.sv */
// Interface carrying the reported code from fault core to the LED sequencer
`timescale 1ns/1ps
`default_nettype none
interface sfm_led_if;
    logic                      valid; // A fault is being reported
    logic [sfm_pkg::CODE_W-1:0] code; // Blink count of the reported fault
    modport src (output valid, output code);
    modport dst (input valid, input code);
endinterface : sfm_led_if
`default_nettype wire

/* File: verilog/sfm_led_blinker.sv */
// LED blink-code sequencer: flashes the reported code, then a pause
`timescale 1ns/1ps
`default_nettype none
module sfm_led_blinker #(
    parameter int unsigned BLINK_CYC = sfm_pkg::BLINK_CYC
) (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic resetn_i,
    // Code to show
    sfm_led_if.dst    rep,
    // LED drive
    output logic      led_o
);
    sfm_pkg::sfm_led_state_t   st_reg, st_next;       // Sequencer state
    logic [31:0]               tmr_reg, tmr_next;     // Phase timer
    logic [sfm_pkg::CODE_W-1:0] cnt_reg, cnt_next;    // Blinks left / gap phases
    logic [sfm_pkg::CODE_W-1:0] code_reg, code_next;  // Code held for a full cycle
    logic                      led_reg, led_next;     // Registered LED drive
    logic                      tdone;                 // Phase timer expired

    assign tdone = (tmr_reg == 32'h0);
    assign led_o = led_reg;

    // Next state: a code is shown whole before a new one is sampled,
    // so a priority change never truncates a blink train
    always_comb begin
        st_next   = st_reg;
        tmr_next  = tdone ? tmr_reg : tmr_reg - 32'h1;
        cnt_next  = cnt_reg;
        code_next = code_reg;
        led_next  = 1'b0;
        unique case (st_reg)
            sfm_pkg::SFM_LED_IDLE: begin
                if (rep.valid && rep.code != sfm_pkg::CODE_NONE) begin
                    code_next = rep.code;
                    cnt_next  = rep.code;
                    tmr_next  = BLINK_CYC[31:0] - 32'h1;
                    // Light now, as on the OFF to ON step, so the first pulse is full width
                    led_next  = 1'b1;
                    st_next   = sfm_pkg::SFM_LED_ON;
                end
            end
            sfm_pkg::SFM_LED_ON: begin
                led_next = 1'b1;
                if (tdone) begin
                    led_next = 1'b0;
                    cnt_next = cnt_reg - 5'h01;
                    tmr_next = BLINK_CYC[31:0] - 32'h1;
                    st_next  = sfm_pkg::SFM_LED_OFF;
                end
            end
            sfm_pkg::SFM_LED_OFF: begin
                if (tdone) begin
                    tmr_next = BLINK_CYC[31:0] - 32'h1;
                    if (cnt_reg == 5'h00) begin
                        cnt_next = sfm_pkg::GAP_BLINKS[sfm_pkg::CODE_W-1:0];
                        st_next  = sfm_pkg::SFM_LED_GAP;
                    end else begin
                        led_next = 1'b1;
                        st_next  = sfm_pkg::SFM_LED_ON;
                    end
                end
            end
            sfm_pkg::SFM_LED_GAP: begin
                if (tdone) begin
                    tmr_next = BLINK_CYC[31:0] - 32'h1;
                    cnt_next = cnt_reg - 5'h01;
                    if (cnt_reg == 5'h01) begin
                        st_next = sfm_pkg::SFM_LED_IDLE;
                    end
                end
            end
        endcase
    end

    // Register stage
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            st_reg   <= sfm_pkg::SFM_LED_IDLE;
            tmr_reg  <= 32'h0;
            cnt_reg  <= 5'h00;
            code_reg <= 5'h00;
            led_reg  <= 1'b0;
        end else begin
            st_reg   <= st_next;
            tmr_reg  <= tmr_next;
            cnt_reg  <= cnt_next;
            code_reg <= code_next;
            led_reg  <= led_next;
        end
    end
endmodule : sfm_led_blinker
`default_nettype wire

/* File: verilog/sfm_fault_manager.sv */
// Servo fault manager: gate disable, latching, auto-recovery, priority report
// Function
// - Any fault immediately removes output stage enable
// - Hold source only for latching-class faults
// - LED blinks the reported fault's code
// - Self-reset faults re-enable after 50-100 ms
// - Enable deassert or power cycle clears latches
// - Report only highest-priority active fault
// - After enable cycle, show next remaining fault
// - Over-voltage non-latching, trips above threshold
// - Over-voltage clears below threshold minus hysteresis
`timescale 1ns/1ps
`default_nettype none
module sfm_fault_manager #(
    // Recovery delay in cycles; shorten for simulation
    parameter int unsigned RECOVER_CYC = sfm_pkg::RECOVER_CYC,
    // LED phase length in cycles; shorten for simulation
    parameter int unsigned BLINK_CYC   = sfm_pkg::BLINK_CYC
) (
    // Clock and reset (reset doubles as control power-on)
    input  wire logic                          ref_clk_i,
    input  wire logic                          resetn_i,
    // Fault detectors, asynchronous levels, active high
    input  wire logic [sfm_pkg::NUM_FAULTS-1:0] fault_det_i,
    // Bus voltage sample and over-voltage thresholds, same clock
    input  wire logic [sfm_pkg::VBUS_W-1:0]     vbus_i,
    input  wire logic [sfm_pkg::VBUS_W-1:0]     ov_trip_i,
    input  wire logic [sfm_pkg::VBUS_W-1:0]     ov_hyst_i,
    // Drive enable pin, asynchronous, active low
    input  wire logic                          drive_en_n_i,
    // Inverter gate enable, high allows switching
    output logic                               gate_en_o,
    // Status
    output logic                               faulted_o,
    output logic [sfm_pkg::CODE_W-1:0]         fault_code_o,
    output logic                               led_o
);
    localparam int unsigned N = sfm_pkg::NUM_FAULTS;

    // Three-stage synchronisers for pins; first stage feeds only the second
    logic [N-1:0] fs1_reg, fs2_reg, fs3_reg;
    logic [N-1:0] fstab_reg, fstab_next;   // Debounced fault levels
    logic [2:0]   es_reg;                  // Enable pin synchroniser
    logic         en_stab_reg, en_stab_next; // Debounced enable, high = enabled
    logic         en_prev_reg;             // Previous enable for edge detect

    // Fault state
    logic         ov_reg, ov_next;         // Over-voltage with hysteresis
    logic [N-1:0] latch_reg, latch_next;   // Latched sources
    logic [31:0]  rec_reg, rec_next;       // Recovery countdown
    logic [sfm_pkg::CODE_W-1:0] code_reg, code_next; // Reported code
    logic         rep_reg, rep_next;       // A fault is reported
    logic         gate_reg, gate_next;     // Registered gate enable

    logic [N-1:0] active;                  // Live plus latched faults
    logic         en_fall;                 // Enable just went to disable state
    logic         en_rise;                 // Enable just re-applied
    logic [N-1:0] ov_vec;                  // Over-voltage placed in its slot

    sfm_led_if rep_if ();

    // Fixed priority: lowest index wins
    function automatic logic [sfm_pkg::CODE_W-1:0] prio_code(input logic [N-1:0] v);
        logic [sfm_pkg::CODE_W-1:0] c;
        c = sfm_pkg::CODE_NONE;
        for (int i = N - 1; i >= 0; i--) begin
            if (v[i]) begin
                c = sfm_pkg::CODE_TABLE[i*sfm_pkg::CODE_W +: sfm_pkg::CODE_W];
            end
        end
        return c;
    endfunction : prio_code

    // Pin synchronisers, one per detector via generate
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_sync
            always_ff @(posedge ref_clk_i) begin
                if (!resetn_i) begin
                    fs1_reg[g] <= 1'b0;
                    fs2_reg[g] <= 1'b0;
                    fs3_reg[g] <= 1'b0;
                end else begin
                    fs1_reg[g] <= fault_det_i[g];
                    fs2_reg[g] <= fs1_reg[g];
                    fs3_reg[g] <= fs2_reg[g];
                end
            end
        end
    endgenerate

    // Enable pin synchroniser; reset as disabled (pin high)
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            es_reg <= 3'h7;
        end else begin
            es_reg <= {es_reg[1:0], drive_en_n_i};
        end
    end

    // Accept a change only when stages two and three agree
    always_comb begin
        fstab_next = fstab_reg;
        for (int i = 0; i < N; i++) begin
            if (fs2_reg[i] == fs3_reg[i]) begin
                fstab_next[i] = fs3_reg[i];
            end
        end
        en_stab_next = en_stab_reg;
        if (es_reg[1] == es_reg[2]) begin
            en_stab_next = ~es_reg[2];
        end
    end

    assign en_fall = en_prev_reg & ~en_stab_reg;
    assign en_rise = ~en_prev_reg & en_stab_reg;

    // Over-voltage comparator with hysteresis band
    always_comb begin
        ov_next = ov_reg;
        if (vbus_i > ov_trip_i) begin
            ov_next = 1'b1;
        end else if ({1'b0, vbus_i} + {1'b0, ov_hyst_i} < {1'b0, ov_trip_i}) begin
            ov_next = 1'b0;
        end
    end

    always_comb begin
        ov_vec         = '0;
        ov_vec[sfm_pkg::OV_IDX] = ov_reg;
    end

    assign active = fstab_reg | ov_vec | latch_reg;

    // Fault state next values
    always_comb begin
        // Latch set wins over the enable clear in the same cycle
        latch_next = latch_reg;
        if (en_fall) begin
            latch_next = '0;
        end
        latch_next = latch_next | (fstab_reg & sfm_pkg::LATCH_MASK);

        // Recovery timer reloads while any fault stands, counts after all clear
        rec_next = rec_reg;
        if (active != '0) begin
            rec_next = RECOVER_CYC[31:0];
        end else if (rec_reg != 32'h0) begin
            rec_next = rec_reg - 32'h1;
        end

        // Gate drops in the cycle a fault is seen, returns after delay
        gate_next = (active == '0) && (rec_reg == 32'h0) && en_stab_reg;

        // Report is frozen while latched until the enable is cycled,
        // then the highest remaining fault is shown
        code_next = code_reg;
        rep_next  = rep_reg;
        if (!rep_reg || en_rise || (latch_reg == '0)) begin
            code_next = prio_code(active);
            rep_next  = (active != '0);
        end
    end

    // Register stage for everything past the synchronisers
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            fstab_reg   <= '0;
            en_stab_reg <= 1'b0;
            en_prev_reg <= 1'b0;
            ov_reg      <= 1'b0;
            latch_reg   <= '0;
            rec_reg     <= 32'h0;
            code_reg    <= sfm_pkg::CODE_NONE;
            rep_reg     <= 1'b0;
            gate_reg    <= 1'b0;
        end else begin
            fstab_reg   <= fstab_next;
            en_stab_reg <= en_stab_next;
            en_prev_reg <= en_stab_reg;
            ov_reg      <= ov_next;
            latch_reg   <= latch_next;
            rec_reg     <= rec_next;
            code_reg    <= code_next;
            rep_reg     <= rep_next;
            gate_reg    <= gate_next;
        end
    end

    // Gate is also cut combinationally so a registered fault stops it at once
    assign gate_en_o    = gate_reg & (active == '0);
    assign faulted_o    = rep_reg;
    assign fault_code_o = code_reg;
    assign rep_if.valid = rep_reg;
    assign rep_if.code  = code_reg;

    // LED sequencer
    sfm_led_blinker #(
        .BLINK_CYC (BLINK_CYC)
    ) u_led (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .rep       (rep_if),
        .led_o     (led_o)
    );
endmodule : sfm_fault_manager
`default_nettype wire

/* File: sim/sfm_fault_manager_properties.sv */
// Concurrent checks on the fault manager top-level ports
`timescale 1ns/1ps
`default_nettype none
module sfm_fault_manager_properties #(
    parameter int unsigned RECOVER_CYC = 20,
    parameter int unsigned BLINK_CYC   = 3
) (
    // Clock and reset
    input wire logic        ref_clk_i,
    input wire logic        resetn_i,
    // Fault side inputs
    input wire logic [7:0]  fault_det_i,
    input wire logic [11:0] vbus_i,
    input wire logic [11:0] ov_trip_i,
    input wire logic [11:0] ov_hyst_i,
    input wire logic        drive_en_n_i,
    // Outputs watched
    input wire logic        gate_en_o,
    input wire logic        faulted_o,
    input wire logic [4:0]  fault_code_o,
    input wire logic        led_o
);
    logic [7:0] hi_cnt; // Cycles the LED has been lit
    logic [7:0] qt_cnt; // Quiet cycles, saturating so reset never looks like a fault
    logic       ov_band; // Bus not yet below trip minus hysteresis
    assign ov_band = ({1'b0, vbus_i} + {1'b0, ov_hyst_i}) >= {1'b0, ov_trip_i};
    // Helper counters for pulse width and recovery delay
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            hi_cnt <= 8'h00;
            qt_cnt <= 8'hff;
        end else begin
            hi_cnt <= led_o ? hi_cnt + 8'h01 : 8'h00;
            if (fault_det_i != 8'h00 || ov_band) qt_cnt <= 8'h00;
            else if (qt_cnt != 8'hff) qt_cnt <= qt_cnt + 8'h01;
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    fault_gate_a: assert property ((fault_det_i != 8'h00)[*5] |-> !gate_en_o)
        else $error("gate enabled while a fault input is high");
    ov_gate_a: assert property ((vbus_i > ov_trip_i)[*3] |-> !gate_en_o)
        else $error("gate enabled while bus is over threshold");
    recover_delay_a: assert property ($rose(gate_en_o) |-> qt_cnt >= RECOVER_CYC)
        else $error("gate enabled too soon after a fault condition");
    latch_hold_a: assert property ((!drive_en_n_i && fault_code_o > 5'h01 && !gate_en_o)[*8]
        |=> !gate_en_o)
        else $error("latched fault released without enable cycle");
    gate_needs_en_a: assert property (drive_en_n_i[*6] |-> !gate_en_o)
        else $error("gate enabled while drive enable is off");
    fault_report_a: assert property ((fault_det_i != 8'h00)[*8] |-> faulted_o)
        else $error("active fault not reported");
    code_range_a: assert property (faulted_o |-> fault_code_o inside {[5'h01:5'h08]})
        else $error("reported code outside table");
    led_phase_a: assert property ($fell(led_o) && faulted_o |-> hi_cnt == BLINK_CYC)
        else $error("LED pulse width wrong");
endmodule : sfm_fault_manager_properties
`default_nettype wire

/* File: sim/sfm_led_watch.sv */
// Status LED observer that counts the pulses of one blink burst
`timescale 1ns/1ps
`default_nettype none
module sfm_led_watch #(
    parameter int unsigned BLINK_CYC = 3
) (
    // Clock and reset
    input  wire logic  ref_clk_i,
    input  wire logic  resetn_i,
    // LED drive seen
    input  wire logic  led_i,
    // Pulses in the last complete burst
    output logic [4:0] count_o
);
    logic       led_q; // Previous LED level
    logic [4:0] run;   // Pulses of the burst in progress
    logic [7:0] dark;  // Cycles unlit; only the gap runs past two phases
    // Burst ends when the LED stays dark longer than two phases
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            led_q <= 1'b0;
            run <= 5'h00;
            dark <= 8'h00;
            count_o <= 5'h00;
        end else begin
            led_q <= led_i;
            dark <= led_i ? 8'h00 : dark + 8'h01;
            if (led_i && !led_q) run <= run + 5'h01;
            if (dark == 2 * BLINK_CYC + 1) begin
                count_o <= run;
                run <= 5'h00;
            end
        end
    end
endmodule : sfm_led_watch
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench for the servo fault manager
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        ref_clk_i = 1'b0; // 50 MHz drive clock
    logic        resetn_i = 1'b0;  // Also stands for a control power cycle
    logic [7:0]  fault_det_i = 8'h00;
    logic [11:0] vbus_i = 12'h400; // Nominal bus, well below trip
    logic [11:0] ov_trip_i = 12'h800;
    logic [11:0] ov_hyst_i = 12'h040;
    logic        drive_en_n_i = 1'b1;
    logic        gate_en_o;
    logic        faulted_o;
    logic [4:0]  fault_code_o;
    logic        led_o;
    logic [4:0]  blinks; // Pulses counted by the LED observer
    int          err_total = 0;
    int          total_checks = 0;
    int          cycles = 0;
    int          took;
    // Short counts keep the run brief
    sfm_fault_manager #(.RECOVER_CYC(20), .BLINK_CYC(3)) sfm_fault_manager_i (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .fault_det_i(fault_det_i),
        .vbus_i(vbus_i), .ov_trip_i(ov_trip_i), .ov_hyst_i(ov_hyst_i),
        .drive_en_n_i(drive_en_n_i), .gate_en_o(gate_en_o), .faulted_o(faulted_o),
        .fault_code_o(fault_code_o), .led_o(led_o));
    sfm_led_watch #(.BLINK_CYC(3)) sfm_led_watch_i (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .led_i(led_o), .count_o(blinks));
    // Clock
    initial begin
        forever #10 ref_clk_i = ~ref_clk_i;
    end
    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            complete_run();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask : cyc
    // Bounded wait for the gate to reach a level
    task automatic wait_gate(input logic lvl, input int lim, output int n);
        n = 0;
        while (gate_en_o !== lvl && n < lim) begin
            cyc(1);
            n++;
        end
        chk("gate reached", {31'h0, gate_en_o}, {31'h0, lvl});
    endtask : wait_gate
    task automatic en_cycle();
        drive_en_n_i = 1'b1;
        cyc(8);
        drive_en_n_i = 1'b0;
    endtask : en_cycle
    task automatic t_latch();
        fault_det_i = 8'h08;
        wait_gate(1'b0, 8, took);
        cyc(3);
        chk("code", {27'h0, fault_code_o}, 32'h4);
        fault_det_i = 8'h00;
        cyc(90);
        chk("gate latched", {31'h0, gate_en_o}, 32'h0);
        chk("blinks", {27'h0, blinks}, 32'h4);
        en_cycle();
        wait_gate(1'b1, 60, took);
    endtask : t_latch
    task automatic t_prio();
        fault_det_i = 8'h24;
        cyc(8);
        chk("prio code", {27'h0, fault_code_o}, 32'h3);
        fault_det_i = 8'h20;
        cyc(30);
        chk("held code", {27'h0, fault_code_o}, 32'h3);
        en_cycle();
        cyc(10);
        chk("next code", {27'h0, fault_code_o}, 32'h6);
        fault_det_i = 8'h00;
        en_cycle();
        wait_gate(1'b1, 60, took);
        chk("code none", {27'h0, fault_code_o}, 32'h0);
    endtask : t_prio
    task automatic t_ov();
        vbus_i = 12'h801;
        wait_gate(1'b0, 6, took);
        cyc(3);
        chk("ov code", {27'h0, fault_code_o}, 32'h1);
        vbus_i = 12'h7d0; // Below trip but inside the hysteresis band
        cyc(40);
        chk("ov band", {31'h0, gate_en_o}, 32'h0);
        vbus_i = 12'h700;
        wait_gate(1'b1, 60, took);
        chk("recover wait", {31'h0, took >= 20}, 32'h1);
    endtask : t_ov
    // Control power cycle in mid-run clears a latch with the enable left on
    task automatic t_power();
        fault_det_i = 8'h10;
        wait_gate(1'b0, 8, took);
        fault_det_i = 8'h00;
        cyc(30);
        chk("pre power gate", {31'h0, gate_en_o}, 32'h0);
        resetn_i = 1'b0;
        cyc(5);
        chk("power code", {26'h0, faulted_o, fault_code_o}, 32'h0);
        resetn_i = 1'b1;
        wait_gate(1'b1, 30, took);
        chk("power report", {31'h0, faulted_o}, 32'h0);
    endtask : t_power
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run
    // Main sequence
    initial begin
        cyc(20);
        chk("reset gate", {31'h0, gate_en_o}, 32'h0);
        chk("reset led", {30'h0, faulted_o, led_o}, 32'h0);
        resetn_i = 1'b1;
        drive_en_n_i = 1'b0;
        wait_gate(1'b1, 30, took);
        t_latch();
        t_prio();
        t_ov();
        t_power();
        complete_run();
    end
endmodule : tb
bind sfm_fault_manager sfm_fault_manager_properties #(
    .RECOVER_CYC(RECOVER_CYC), .BLINK_CYC(BLINK_CYC)) sfm_fault_manager_properties_i (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .fault_det_i(fault_det_i),
    .vbus_i(vbus_i), .ov_trip_i(ov_trip_i), .ov_hyst_i(ov_hyst_i),
    .drive_en_n_i(drive_en_n_i), .gate_en_o(gate_en_o), .faulted_o(faulted_o),
    .fault_code_o(fault_code_o), .led_o(led_o));
`default_nettype wire
